// ---- bench/smbat_bench.sv ----
module smbat_bench
  import smbat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [6:0] DEV = 7'h40;
  typedef struct packed {
    logic [15:0] fault;
    logic [15:0] mask;
    logic        alert;
  } smbat_row_t;
  // Alert is the line level: low means asserted
  smbat_row_t rows [6] = '{
    '{16'h0000, 16'h0000, 1'b1}, '{16'h0001, 16'h0000, 1'b0},
    '{16'h0003, 16'h0001, 1'b0}, '{16'h0003, 16'h0003, 1'b1},
    '{16'h8000, 16'h7fff, 1'b0}, '{16'hffff, 16'hffff, 1'b1}};

  logic        ref_clk_i;
  logic        reset_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic [15:0] fault;
  logic [15:0] st;
  logic [15:0] am;
  logic [15:0] aam;
  logic        stretch;
  logic        tmo;
  logic        pslverr;
  int          low_seen = 0;
  int          miscompares;
  int          check_count;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  smbat_if lnk ();

  always @(posedge ref_clk_i)
    if (!lnk.scl_line)
      low_seen <= low_seen + 1;

  smbat_dev #(.DEV_ADDR(DEV)) i_smbat_dev (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .clk_en_i(1'b1), .bus(lnk), .fault_i(fault), .stretch_req_i(stretch), .status_o(st),
    .alert_mask_o(am), .auto_alert_mask_o(aam), .timeout_o(tmo));

  smbat_host i_smbat_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus(lnk));

  smbat_chk #(.DEV_ADDR(DEV)) i_smbat_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .scl_line(lnk.scl_line), .scl_oe_dev(lnk.scl_oe_dev), .scl_oe_host(lnk.scl_oe_host),
    .start_host(lnk.start_host),
    .byte_host_vld(lnk.byte_host_vld), .byte_host(lnk.byte_host),
    .byte_dev_vld(lnk.byte_dev_vld), .byte_dev(lnk.byte_dev),
    .alert_line(lnk.alert_line));

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Busy is polled so link latency is never assumed
  task automatic op(input smbat_op_t o, input logic [6:0] dv, input logic [15:0] wd);
    int n;
    apb(1'b1, HREG_WDATA, {16'h0000, wd});
    apb(1'b1, HREG_CTRL, (32'(dv) << CTRL_DEV_LSB) | (32'h1 << CTRL_GO_BIT) | 32'(o));
    n = 0;
    do
    begin
      apb(1'b0, HREG_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      miscompares++;
      test_done();
    end
  endtask : op

  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    miscompares++;
    test_done();
  end

  initial
  begin
    reset_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault = 16'h0000;
    stretch = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(32'(am), 32'(ALERT_MASK_RESET));
    chk(32'(aam), 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      fault <= rows[i].fault;
      op(SMBAT_OP_WMASK, DEV, rows[i].mask);
      chk(32'(am), 32'(rows[i].mask));
      chk(32'(st), 32'(rows[i].fault));
      chk(32'(lnk.alert_line), 32'(rows[i].alert));
    end
    $display("mask table test done");
    stretch <= 1'b1;
    op(SMBAT_OP_WMASK, DEV, 16'h00ff);
    stretch <= 1'b0;
    chk(32'(am), 32'h00ff);
    chk(32'(low_seen != 0), 32'h1);
    chk(32'(tmo), 32'h0);
    $display("stretch test done");
    fault <= 16'h0000;
    op(SMBAT_OP_WMASK, DEV, 16'h0000);
    op(SMBAT_OP_ARA, DEV, 16'h0000);
    chk(32'(rd[ST_WON_BIT]), 32'h0);
    chk(32'(aam), 32'h0);
    fault <= 16'h0005;
    op(SMBAT_OP_ARA, DEV, 16'h0000);
    chk(32'(rd[ST_WON_BIT]), 32'h1);
    chk(32'(aam), 32'h0005);
    chk(32'(st), 32'h0005);
    chk(32'(lnk.alert_line), 32'h1);
    apb(1'b0, HREG_ARA_ADDR, 32'h0);
    chk(rd, 32'(DEV));
    fault <= 16'h0105;
    repeat (3) @(posedge ref_clk_i);
    chk(32'(lnk.alert_line), 32'h0);
    chk(32'(aam), 32'h0005);
    op(SMBAT_OP_ARA, DEV, 16'h0000);
    chk(32'(aam), 32'h0105);
    chk(32'(lnk.alert_line), 32'h1);
    op(SMBAT_OP_CLEAR, 7'h41, 16'h0000);
    chk(32'(aam), 32'h0105);
    chk(32'(lnk.alert_line), 32'h1);
    op(SMBAT_OP_CLEAR, DEV, 16'h0000);
    chk(32'(aam), 32'h0);
    chk(32'(lnk.alert_line), 32'h0);
    chk(32'(rd[ST_ALERT_BIT]), 32'h1);
    apb(1'b0, HREG_CTRL, 32'h0);
    chk(rd, (32'(DEV) << CTRL_DEV_LSB) | 32'(SMBAT_OP_CLEAR));
    $display("alert response test done");
    fault <= 16'h0000;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(32'(pslverr), 32'h0);
    $display("unmapped read test done");
    test_done();
  end
endmodule : smbat_bench

// ---- bench/smbat_chk.sv ----
module smbat_chk
  import smbat_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Link signals
  input  wire logic       scl_line,
  input  wire logic       scl_oe_dev,
  input  wire logic       scl_oe_host,
  input  wire logic       start_host,
  input  wire logic       byte_host_vld,
  input  wire logic [7:0] byte_host,
  input  wire logic       byte_dev_vld,
  input  wire logic [7:0] byte_dev,
  input  wire logic       alert_line
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  logic [CNT_W-1:0] low_reg;
  logic [CNT_W-1:0] low_next;
  logic [CNT_W-1:0] str_reg;
  logic [CNT_W-1:0] str_next;
  logic [CNT_W-1:0] hst_reg;
  logic [CNT_W-1:0] hst_next;

  // Stretch is counted per message, so a new start restarts the budget
  always_comb
  begin
    low_next = scl_line ? '0 : low_reg + 1'b1;
    str_next = start_host ? '0 : str_reg + CNT_W'(scl_oe_dev);
    // Host budget restarts at each byte boundary
    hst_next = (start_host || byte_host_vld) ? '0 : hst_reg + CNT_W'(scl_oe_host);
  end

  always_ff @(posedge ref_clk_i)
  begin
    low_reg <= reset_i ? '0 : low_next;
    str_reg <= reset_i ? '0 : str_next;
    hst_reg <= reset_i ? '0 : hst_next;
  end

  sequence ara_req_s;
    byte_host_vld && byte_host == {ARA_ADDR, 1'b1};
  endsequence

  sequence win_s;
    byte_dev_vld ##2 (byte_host_vld && byte_host == $past(byte_dev, 2));
  endsequence

  ara_answer_a : assert property (ara_req_s and !alert_line |=>
    byte_dev_vld && byte_dev == {DEV_ADDR, 1'b1})
    else $error("alerting device gave no address answer");
  ara_silent_a : assert property (ara_req_s and alert_line |=> !byte_dev_vld)
    else $error("device answered without an alert");
  answer_cause_a : assert property (byte_dev_vld |->
    $past(byte_host_vld) && $past(byte_host) == {ARA_ADDR, 1'b1})
    else $error("address answer without a response read");
  alert_release_a : assert property (win_s |=> alert_line)
    else $error("alert not released after a won response read");
  start_byte_a : assert property (start_host |=> byte_host_vld)
    else $error("no address byte after start");
  byte_gap_a : assert property (byte_host_vld |=> !byte_host_vld)
    else $error("host bytes closer than two cycles");
  clock_low_a : assert property (low_reg <= TIMEOUT_MAX_CYC)
    else $error("clock held low past the reset limit");
  dev_stretch_a : assert property (str_reg <= TGT_STRETCH_CYC)
    else $error("device stretch budget exceeded");
  host_stretch_a : assert property (hst_reg <= HOST_STRETCH_CYC)
    else $error("host stretch budget exceeded");

  win_c : cover property (win_s);
endmodule : smbat_chk

// ---- rtl/smbat_dev.sv ----
// What this block does
// - Clock low past 25 ms means timeout
// - Reset interface within 35 ms of low
// - Own stretch under 25 ms per message
// - Host stretch under 10 ms per byte
// - Alert gated by software and automatic masks
// - Response read returns lowest alerting address
// - Win only if own address was sent
// - Release alert at once after win
// - Win sets automatic mask for active faults
// - Automatic mask leaves status untouched
// - Auto-masked fault silent until clear-faults
// - Shared line idles after last responder
// - Host sends clear-faults after every alert; here only when software issues SMBAT_OP_CLEAR
module smbat_dev
  import smbat_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  input  wire logic               clk_en_i,
  // Link
  smbat_if.dev                    bus,
  // Fault detectors and status
  input  wire logic [FAULT_W-1:0] fault_i,
  input  wire logic               stretch_req_i,
  output logic [FAULT_W-1:0]      status_o,
  output logic [FAULT_W-1:0]      alert_mask_o,
  output logic [FAULT_W-1:0]      auto_alert_mask_o,
  output logic                    timeout_o
);
  if (DEV_ADDR == ARA_ADDR)
  begin : g_addr_chk
    $error("smbat_dev: address collides with response address");
  end

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_CMD,
    D_DLO,
    D_DHI,
    D_ARA,
    D_IGNORE
  } smbat_dst_t;

  smbat_dst_t       st_reg;
  smbat_dst_t       st_next;
  logic [FAULT_W-1:0] mask_reg;
  logic [FAULT_W-1:0] mask_next;
  logic [FAULT_W-1:0] auto_reg;
  logic [FAULT_W-1:0] auto_next;
  logic [7:0]       dlo_reg;
  logic [7:0]       dlo_next;
  logic             stretch_reg;
  logic             stretch_next;
  logic             sda_reg;
  logic             sda_next;
  logic [7:0]       tx_reg;
  logic [7:0]       tx_next;
  logic             txv_reg;
  logic             txv_next;
  logic             clk_low;
  logic             to_hit;
  logic             sx_hit;
  logic             in_msg;
  logic             alert_want;

  assign clk_low = ~bus.scl_line;
  assign in_msg  = (st_reg != D_IDLE);

  // timeout detection, acted on at once (well inside 35 ms)
  smbat_low_timer #(.LIMIT(TIMEOUT_MIN_CYC)) u_to (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .level_i   (clk_low & in_msg),
    .clear_i   (~clk_low),
    .expired_o (to_hit)
  );

  smbat_low_timer #(.LIMIT(TGT_STRETCH_CYC)) u_sx (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .level_i   (stretch_reg),
    .clear_i   (bus.start_host | ~in_msg),
    .expired_o (sx_hit)
  );

  // alert when an unmasked fault is not auto-masked
  assign alert_want = |(fault_i & ~mask_reg & ~auto_reg);

  always_comb
  begin
    st_next      = st_reg;
    mask_next    = mask_reg;
    auto_next    = auto_reg;
    dlo_next     = dlo_reg;
    stretch_next = stretch_reg;
    sda_next     = 1'b0;
    tx_next      = tx_reg;
    txv_next     = 1'b0;
    if (to_hit || sx_hit)
    begin
      // drop both lines and ignore the rest of the message (D_IGNORE)
      st_next      = D_IGNORE;
      stretch_next = 1'b0;
    end
    else if (bus.stop_host)
    begin
      st_next      = D_IDLE;
      stretch_next = 1'b0;
    end
    else if (bus.start_host)
    begin
      st_next      = D_ADDR;
      stretch_next = 1'b0;
    end
    else
    begin
      // Stretch only inside a message and never while in D_IGNORE
      stretch_next = stretch_req_i & in_msg & (st_reg != D_IGNORE);
      if (bus.byte_host_vld)
      begin
        unique case (st_reg)
          D_IDLE, D_IGNORE: st_next = st_reg;
          D_ADDR:
          begin
            if (bus.byte_host[7:1] == ARA_ADDR && bus.byte_host[0] && alert_want)
            begin
              // drive our address; arbitration resolves on the host echo in D_ARA
              st_next  = D_ARA;
              tx_next  = {DEV_ADDR, 1'b1};
              txv_next = 1'b1;
            end
            else if (bus.byte_host[7:1] == DEV_ADDR && !bus.byte_host[0])
              st_next = D_CMD;
            else
              st_next = D_IGNORE;
          end
          D_CMD:
          begin
            if (bus.byte_host == CLEAR_FAULTS_CMD)
            begin
              auto_next = '0;
              st_next   = D_IGNORE;
            end
            else if (bus.byte_host == ALERT_MASK_CMD)
              st_next = D_DLO;
            else
              st_next = D_IGNORE;
          end
          D_DLO:
          begin
            dlo_next = bus.byte_host;
            st_next  = D_DHI;
          end
          D_DHI:
          begin
            mask_next = {bus.byte_host, dlo_reg};
            st_next   = D_IGNORE;
          end
          D_ARA:
          begin
            // won only if the byte on the line is our own address
            if (bus.byte_host[7:1] == DEV_ADDR)
            begin
              // mask faults active now; status untouched
              auto_next = auto_reg | fault_i;
            end
            st_next = D_IGNORE;
          end
          default: st_next = D_IGNORE;
        endcase
      end
      // Hold data low for each D_ARA cycle that has no stop, start or timeout while answering
      if (st_reg == D_ARA)
        sda_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_reg      <= D_IDLE;
      mask_reg    <= ALERT_MASK_RESET;
      auto_reg    <= '0;
      dlo_reg     <= 8'h00;
      stretch_reg <= 1'b0;
      sda_reg     <= 1'b0;
      tx_reg      <= 8'h00;
      txv_reg     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_reg      <= st_next;
      mask_reg    <= mask_next;
      auto_reg    <= auto_next;
      dlo_reg     <= dlo_next;
      stretch_reg <= stretch_next;
      sda_reg     <= sda_next;
      tx_reg      <= tx_next;
      txv_reg     <= txv_next;
    end
  end

  assign timeout_o         = to_hit | sx_hit;
  assign bus.scl_oe_dev    = stretch_reg;
  // Data is only a presence marker here; the address byte rides byte_dev
  assign bus.sda_oe_dev    = sda_reg;
  // open-drain: line idles only when no target pulls it
  assign bus.alert_oe_dev  = alert_want;
  assign bus.byte_dev      = tx_reg;
  assign bus.byte_dev_vld  = txv_reg;
  assign status_o          = fault_i;
  assign alert_mask_o      = mask_reg;
  assign auto_alert_mask_o = auto_reg;
endmodule : smbat_dev

// ---- rtl/smbat_host.sv ----
// Host controller end: APB slave for software, byte-level framer on the link.
//
// Our own choice: the APB interface to the registers.
module smbat_host
  import smbat_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Link
  smbat_if.host            bus
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_BYTE,
    H_WAIT,
    H_STOP
  } smbat_hst_t;

  smbat_hst_t  st_reg;
  smbat_hst_t  st_next;
  smbat_op_t   op_reg;
  smbat_op_t   op_next;
  logic [6:0]  dev_reg;
  logic [6:0]  dev_next;
  logic [15:0] wd_reg;
  logic [15:0] wd_next;
  logic [2:0]  idx_reg;
  logic [2:0]  idx_next;
  logic [6:0]  ara_reg;
  logic [6:0]  ara_next;
  logic        won_reg;
  logic        won_next;
  logic        to_reg;
  logic        to_next;
  logic        start_r;
  logic        stop_r;
  logic [7:0]  byte_r;
  logic        bvld_r;
  logic        start_n;
  logic        stop_n;
  logic [7:0]  byte_n;
  logic        bvld_n;
  logic        to_hit;
  logic        wr_acc;
  logic        busy;

  assign busy   = (st_reg != H_IDLE);
  assign wr_acc = psel_i & penable_i & pwrite_i;

  // host side timeout on clock held low
  smbat_low_timer #(.LIMIT(TIMEOUT_MIN_CYC)) u_to (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .level_i   (~bus.scl_line & busy),
    .clear_i   (bus.scl_line),
    .expired_o (to_hit)
  );

  // Byte sequence for each operation; last index ends the message
  function automatic logic [7:0] op_byte(input smbat_op_t op, input logic [2:0] i,
                                         input logic [6:0] dev, input logic [15:0] wd);
    logic [7:0] b;
    b = 8'h00;
    unique case (op)
      SMBAT_OP_ARA:   b = (i == 3'd0) ? {ARA_ADDR, 1'b1} : 8'h00;
      SMBAT_OP_CLEAR: b = (i == 3'd0) ? {dev, 1'b0} : CLEAR_FAULTS_CMD;
      SMBAT_OP_WMASK:
        b = (i == 3'd0) ? {dev, 1'b0} : (i == 3'd1) ? ALERT_MASK_CMD :
            (i == 3'd2) ? wd[7:0] : wd[15:8];
      SMBAT_OP_NONE:  b = 8'h00;
    endcase
    return b;
  endfunction : op_byte

  function automatic logic [2:0] op_last(input smbat_op_t op);
    return (op == SMBAT_OP_WMASK) ? 3'd3 : (op == SMBAT_OP_NONE) ? 3'd0 : 3'd1;
  endfunction : op_last

  always_comb
  begin
    st_next  = st_reg;
    op_next  = op_reg;
    dev_next = dev_reg;
    wd_next  = wd_reg;
    idx_next = idx_reg;
    ara_next = ara_reg;
    won_next = won_reg;
    to_next  = to_reg;
    start_n  = 1'b0;
    stop_n   = 1'b0;
    byte_n   = 8'h00;
    bvld_n   = 1'b0;
    if (wr_acc && paddr_i == HREG_WDATA && !busy)
      wd_next = pwdata_i[15:0];
    if (to_hit && busy)
    begin
      // abandon the transfer and release the lines
      to_next = 1'b1;
      stop_n  = 1'b1;
      st_next = H_IDLE;
    end
    else
    begin
      unique case (st_reg)
        H_IDLE:
          if (wr_acc && paddr_i == HREG_CTRL && pwdata_i[CTRL_GO_BIT])
          begin
            op_next  = smbat_op_t'(pwdata_i[CTRL_OP_LSB +: 2]);
            dev_next = pwdata_i[CTRL_DEV_LSB +: 7];
            idx_next = 3'd0;
            won_next = 1'b0;
            to_next  = 1'b0;
            st_next  = H_START;
          end
        H_START:
        begin
          start_n = 1'b1;
          st_next = H_BYTE;
        end
        H_BYTE:
        begin
          byte_n  = op_byte(op_reg, idx_reg, dev_reg, wd_reg);
          bvld_n  = 1'b1;
          st_next = H_WAIT;
        end
        H_WAIT:
        begin
          if (bus.byte_dev_vld)
          begin
            ara_next = bus.byte_dev[7:1];
            won_next = 1'b1;
          end
          // A response read nobody answers ends after one extra wait cycle
          if (op_reg == SMBAT_OP_ARA && idx_reg == 3'd0 && !bus.byte_dev_vld)
            st_next = bvld_r ? H_WAIT : H_STOP;
          else if (idx_reg == op_last(op_reg))
            st_next = H_STOP;
          else
          begin
            idx_next = idx_reg + 3'd1;
            st_next  = H_BYTE;
          end
          if (op_reg == SMBAT_OP_ARA && idx_reg == 3'd0 && bus.byte_dev_vld)
          begin
            // Echo the won address so responders can compare it
            idx_next = 3'd1;
            st_next  = H_BYTE;
          end
        end
        H_STOP:
        begin
          stop_n  = 1'b1;
          st_next = H_IDLE;
        end
        default: st_next = H_IDLE;
      endcase
      if (st_reg == H_BYTE && op_reg == SMBAT_OP_ARA && idx_reg == 3'd1)
        byte_n = {ara_reg, 1'b1};
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_reg  <= H_IDLE;
      op_reg  <= SMBAT_OP_NONE;
      dev_reg <= 7'h00;
      wd_reg  <= 16'h0000;
      idx_reg <= 3'd0;
      ara_reg <= 7'h00;
      won_reg <= 1'b0;
      to_reg  <= 1'b0;
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      byte_r  <= 8'h00;
      bvld_r  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_reg  <= st_next;
      op_reg  <= op_next;
      dev_reg <= dev_next;
      wd_reg  <= wd_next;
      idx_reg <= idx_next;
      ara_reg <= ara_next;
      won_reg <= won_next;
      to_reg  <= to_next;
      start_r <= start_n;
      stop_r  <= stop_n;
      byte_r  <= byte_n;
      bvld_r  <= bvld_n;
    end
  end

  // host never holds the clock low itself
  assign bus.scl_oe_host   = 1'b0;
  assign bus.sda_oe_host   = 1'b0;
  assign bus.start_host    = start_r;
  assign bus.stop_host     = stop_r;
  assign bus.byte_host     = byte_r;
  assign bus.byte_host_vld = bvld_r;

  // Zero-wait APB slave
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  always_comb
  begin
    prdata_o = 32'h0000_0000;
    unique case (paddr_i)
      HREG_STATUS:
        prdata_o = {27'h0, 1'b0, ~bus.alert_line, won_reg, to_reg, busy};
      HREG_ARA_ADDR: prdata_o = {25'h0, ara_reg};
      HREG_WDATA:    prdata_o = {16'h0, wd_reg};
      HREG_CTRL:     prdata_o = {17'h0, dev_reg, 3'h0, 1'b0, 2'h0, op_reg};
      default:       prdata_o = 32'h0000_0000;
    endcase
  end
endmodule : smbat_host

// ---- rtl/smbat_if.sv ----
// Abstract management-bus link between host and target. Open-drain lines are
// resolved here from the output enables: a line is low when any party drives.
interface smbat_if;
  logic scl_oe_host;
  logic scl_oe_dev;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic alert_oe_dev;
  // Framing strobes from the host: start, byte end (ack point), stop
  logic start_host;
  logic stop_host;
  logic [7:0] byte_host;
  logic byte_host_vld;
  logic [7:0] byte_dev;
  logic byte_dev_vld;
  logic scl_line;
  logic sda_line;
  logic alert_line;

  assign scl_line   = ~(scl_oe_host | scl_oe_dev);
  assign sda_line   = ~(sda_oe_host | sda_oe_dev);
  assign alert_line = ~alert_oe_dev;

  modport host (
    output scl_oe_host, sda_oe_host, start_host, stop_host, byte_host, byte_host_vld,
    input  scl_line, sda_line, alert_line, byte_dev, byte_dev_vld
  );
  modport dev (
    output scl_oe_dev, sda_oe_dev, alert_oe_dev, byte_dev, byte_dev_vld,
    input  scl_line, sda_line, start_host, stop_host, byte_host, byte_host_vld
  );
endinterface : smbat_if

// ---- rtl/smbat_low_timer.sv ----
// Counts cycles while a level is high; flags expired every cycle at the limit while the level stays high.
module smbat_low_timer
  import smbat_pkg::*;
#(
  parameter int unsigned LIMIT = TIMEOUT_MIN_CYC
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  // Measured level
  input  wire logic level_i,
  input  wire logic clear_i,
  output logic      expired_o
);
  // Refuse limits the counter cannot reach
  if (LIMIT < 2 || LIMIT >= (1 << CNT_W))
  begin : g_limit_chk
    $error("smbat_low_timer: LIMIT out of range");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             exp_reg;
  logic             exp_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (clear_i)
      cnt_next = '0;
    else if (level_i)
    begin
      if (cnt_reg == LIMIT[CNT_W-1:0])
        exp_next = 1'b1;
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired_o = exp_reg;
endmodule : smbat_low_timer

// ---- rtl/smbat_pkg.sv ----
package smbat_pkg;
  // Clock rate and timing figures
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned TIMEOUT_MIN_MS    = 25;
  localparam int unsigned TIMEOUT_MAX_MS    = 35;
  localparam int unsigned TARGET_STRETCH_MS = 25;
  localparam int unsigned HOST_STRETCH_MS   = 10;
  localparam int unsigned TIMEOUT_MIN_CYC   = TIMEOUT_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMEOUT_MAX_CYC   = TIMEOUT_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned TGT_STRETCH_CYC   = TARGET_STRETCH_MS * (CLK_HZ / 1000);
  localparam int unsigned HOST_STRETCH_CYC  = HOST_STRETCH_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W             = 20;

  // Device register map
  localparam logic [7:0]  ALERT_MASK_CMD    = 8'hd8;
  localparam logic [7:0]  CLEAR_FAULTS_CMD  = 8'h03;
  localparam logic [15:0] ALERT_MASK_RESET  = 16'h0000;
  localparam int unsigned FAULT_W           = 16;
  localparam logic [6:0]  ARA_ADDR          = 7'h0c;

  // Host controller APB registers
  localparam logic [7:0]  HREG_CTRL         = 8'h00;
  localparam logic [7:0]  HREG_STATUS       = 8'h04;
  localparam logic [7:0]  HREG_ARA_ADDR     = 8'h08;
  localparam logic [7:0]  HREG_WDATA        = 8'h0c;
  // Control fields
  localparam int unsigned CTRL_OP_LSB       = 0;
  localparam int unsigned CTRL_GO_BIT       = 4;
  localparam int unsigned CTRL_DEV_LSB      = 8;
  // Status fields
  localparam int unsigned ST_BUSY_BIT       = 0;
  localparam int unsigned ST_TIMEOUT_BIT    = 1;
  localparam int unsigned ST_WON_BIT        = 2;
  localparam int unsigned ST_ALERT_BIT      = 3;
  localparam int unsigned ST_HSTRETCH_BIT   = 4;

  typedef enum logic [1:0] {
    SMBAT_OP_ARA,
    SMBAT_OP_CLEAR,
    SMBAT_OP_WMASK,
    SMBAT_OP_NONE
  } smbat_op_t;
endpackage : smbat_pkg
